// File: inc/btc_pkg.sv
// Constants, field layouts and carrier types of the basic timer control block.
// Assumes one timer clock domain and a 32-bit APB register port.
package btc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned TRS_W  = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_EVENT_GEN = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_COUNT     = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_DIVIDER   = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_RELOAD    = 12'h02c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RUN          = 0;
  localparam int unsigned BIT_UPD_DISABLE  = 1;
  localparam int unsigned BIT_UPD_SOURCE   = 2;
  localparam int unsigned BIT_ONE_PULSE    = 3;
  localparam int unsigned BIT_RELOAD_BUF   = 7;
  localparam int unsigned TRS_LSB          = 4;
  localparam int unsigned BIT_FORCE_UPDATE = 0;
  localparam int unsigned BIT_UPD_FLAG     = 0;
  localparam int unsigned BIT_IRQ_EN       = 0;
  localparam int unsigned BIT_DMA_EN       = 8;

  // ----------------------------------------------------------------
  // Trigger source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [TRS_W-1:0] TRS_RESET  = 3'h0;
  localparam logic [TRS_W-1:0] TRS_ENABLE = 3'h1;
  localparam logic [TRS_W-1:0] TRS_UPDATE = 3'h2;

  localparam logic [CNT_W-1:0]  CNT_RST     = 16'h0000;
  localparam logic [CNT_W-1:0]  DIVIDER_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  RELOAD_RST  = 16'hffff;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reload_buffer_en;
    logic one_pulse_sel;
    logic update_source_sel;
    logic update_disable;
    logic counter_run;
  } btc_ctrl_s;

  typedef struct packed {
    logic dma_en;
    logic irq_en;
  } btc_mask_s;

  localparam btc_ctrl_s CTRL_RST = '{default: 1'b0};
  localparam btc_mask_s MASK_RST = '{default: 1'b0};

endpackage

// File: rtl/btc_time_base.sv
// Prescaler and 16-bit up counter of the timer.
// Assumes all controls come from logic on the same clock.
`timescale 1ns/10ps
module btc_time_base #(
  parameter int unsigned CNT_W = btc_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // Control
  input  wire logic             run_i,
  input  wire logic             reinit_i,
  input  wire logic             cnt_load_i,
  input  wire logic [CNT_W-1:0] cnt_wdata_i,
  input  wire logic [CNT_W-1:0] divider_i,
  input  wire logic [CNT_W-1:0] reload_i,
  // State
  output logic      [CNT_W-1:0] cnt_o,
  output logic                  ovf_o
);

  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] cnt_r;
  logic             tick;

  assign tick  = run_i && (div_r == divider_i);
  // Overflow only from a real count step, never from a reinit or a write
  assign ovf_o = tick && !reinit_i && !cnt_load_i && (cnt_r == reload_i);
  assign cnt_o = cnt_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      div_r <= btc_pkg::CNT_RST;
    end else if (reinit_i) begin
      div_r <= btc_pkg::CNT_RST;
    end else if (run_i) begin
      div_r <= tick ? btc_pkg::CNT_RST : div_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= btc_pkg::CNT_RST;
    end else if (reinit_i) begin
      cnt_r <= btc_pkg::CNT_RST;
    end else if (cnt_load_i) begin
      cnt_r <= cnt_wdata_i;
    end else if (tick) begin
      cnt_r <= (cnt_r == reload_i) ? btc_pkg::CNT_RST : cnt_r + 1'b1;
    end
  end

endmodule

// File: rtl/btc_timer.sv
// Basic timer control: APB register file, update event logic, one-pulse stop,
// reload buffering, update interrupt and the trigger output to slave timers.
// Assumes slave-mode signals come from logic on sys_clk_i; APB on the same clock.
`timescale 1ns/10ps

// What this block does
// - Reload buffer bit defers reload until update
// - One-pulse mode clears run on update
// - Source bit 0: all updates raise request
// - Source bit 1: only overflow raises request
// - Updates enabled: events load shadow registers
// - Updates disabled: no events, shadows hold
// - Force update or slave reset reinitialises counter
// - Run bit gates counting; controls reset zero
// - Three-bit field selects trigger output source
// - Code 000 sends force update or slave reset pulse
// - Code 001 sends run OR gate input
// - Code 010 sends update event
// - Count zero to reload, wrap, overflow
// - Counting starts one cycle after run set
module btc_timer #(
  parameter int unsigned            CNT_W      = btc_pkg::CNT_W,
  parameter logic [CNT_W-1:0]       RELOAD_INI = btc_pkg::RELOAD_RST
) (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       sys_rst_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [btc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [btc_pkg::DATA_W-1:0] pwdata_i,
  output logic      [btc_pkg::DATA_W-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Slave mode controller
  input  wire logic                       slv_reset_i,
  input  wire logic                       slv_update_i,
  input  wire logic                       gate_trig_i,
  // Events out
  output logic                            trigger_out_o,
  output logic                            irq_o,
  output logic                            dma_req_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [btc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == btc_pkg::OFS_CTRL_ONE)  || (a == btc_pkg::OFS_CTRL_TWO) ||
                (a == btc_pkg::OFS_IRQ_MASK)  || (a == btc_pkg::OFS_STATUS)   ||
                (a == btc_pkg::OFS_EVENT_GEN) || (a == btc_pkg::OFS_COUNT)    ||
                (a == btc_pkg::OFS_DIVIDER)   || (a == btc_pkg::OFS_RELOAD);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  btc_pkg::btc_ctrl_s             ctrl_r;
  btc_pkg::btc_mask_s             mask_r;
  logic [btc_pkg::TRS_W-1:0]      master_trigger_sel_r;
  logic                           upd_flag_r;
  logic [CNT_W-1:0]               divider_pre_r;
  logic [CNT_W-1:0]               divider_act_r;
  logic [CNT_W-1:0]               reload_pre_r;
  logic [CNT_W-1:0]               reload_shd_r;
  logic [CNT_W-1:0]               reload_value;
  logic [CNT_W-1:0]               cnt;
  logic                           ovf;
  logic                           access;
  logic                           commit;
  logic                           wr_commit;
  logic                           pready_r;
  logic                           pready_nxt;
  logic                           pslverr_r;
  logic [btc_pkg::DATA_W-1:0]     prdata_r;
  logic [btc_pkg::DATA_W-1:0]     rd_data;
  logic                           wr_ctrl_one;
  logic                           wr_ctrl_two;
  logic                           wr_mask;
  logic                           wr_status;
  logic                           wr_count;
  logic                           wr_divider;
  logic                           wr_reload;
  logic                           force_update;
  logic                           reinit;
  logic                           update_event;
  logic                           flag_set;
  logic                           counter_run_signal;
  logic                           trigger_out_r;
  logic                           trigger_out_nxt;
  logic                           irq_r;
  logic                           dma_req_r;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: the access phase sees pready low for one cycle, so read
  // data is registered and every top output stays a flip-flop.
  assign access     = psel_i && penable_i;
  assign pready_nxt = access && !pready_r;
  assign commit     = access && pready_r;
  assign wr_commit  = commit && pwrite_i && is_mapped(paddr_i);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pready_nxt && !is_mapped(paddr_i);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prdata_r <= btc_pkg::DATA_ZERO;
    end else if (pready_nxt && !pwrite_i) begin
      prdata_r <= rd_data;
    end else if (commit) begin
      prdata_r <= btc_pkg::DATA_ZERO;
    end
  end

  assign wr_ctrl_one  = wr_commit && (paddr_i == btc_pkg::OFS_CTRL_ONE);
  assign wr_ctrl_two  = wr_commit && (paddr_i == btc_pkg::OFS_CTRL_TWO);
  assign wr_mask      = wr_commit && (paddr_i == btc_pkg::OFS_IRQ_MASK);
  assign wr_status    = wr_commit && (paddr_i == btc_pkg::OFS_STATUS);
  assign wr_count     = wr_commit && (paddr_i == btc_pkg::OFS_COUNT);
  assign wr_divider   = wr_commit && (paddr_i == btc_pkg::OFS_DIVIDER);
  assign wr_reload    = wr_commit && (paddr_i == btc_pkg::OFS_RELOAD);
  assign force_update = wr_commit && (paddr_i == btc_pkg::OFS_EVENT_GEN) &&
                        pwdata_i[btc_pkg::BIT_FORCE_UPDATE];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = btc_pkg::DATA_ZERO;
    case (paddr_i)
      btc_pkg::OFS_CTRL_ONE: begin
        rd_data[btc_pkg::BIT_RUN]         = ctrl_r.counter_run;
        rd_data[btc_pkg::BIT_UPD_DISABLE] = ctrl_r.update_disable;
        rd_data[btc_pkg::BIT_UPD_SOURCE]  = ctrl_r.update_source_sel;
        rd_data[btc_pkg::BIT_ONE_PULSE]   = ctrl_r.one_pulse_sel;
        rd_data[btc_pkg::BIT_RELOAD_BUF]  = ctrl_r.reload_buffer_en;
      end
      btc_pkg::OFS_CTRL_TWO: begin
        rd_data[btc_pkg::TRS_LSB +: btc_pkg::TRS_W] = master_trigger_sel_r;
      end
      btc_pkg::OFS_IRQ_MASK: begin
        rd_data[btc_pkg::BIT_IRQ_EN] = mask_r.irq_en;
        rd_data[btc_pkg::BIT_DMA_EN] = mask_r.dma_en;
      end
      btc_pkg::OFS_STATUS: begin
        rd_data[btc_pkg::BIT_UPD_FLAG] = upd_flag_r;
      end
      btc_pkg::OFS_COUNT: begin
        rd_data[CNT_W-1:0] = cnt;
      end
      btc_pkg::OFS_DIVIDER: begin
        rd_data[CNT_W-1:0] = divider_pre_r;
      end
      btc_pkg::OFS_RELOAD: begin
        rd_data[CNT_W-1:0] = reload_pre_r;
      end
      default: begin
        rd_data = btc_pkg::DATA_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // A software write of the run bit in the same cycle as a one-pulse stop
  // wins, since it is the newer intent.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= btc_pkg::CTRL_RST;
    end else if (wr_ctrl_one) begin
      ctrl_r.counter_run       <= pwdata_i[btc_pkg::BIT_RUN];
      ctrl_r.update_disable    <= pwdata_i[btc_pkg::BIT_UPD_DISABLE];
      ctrl_r.update_source_sel <= pwdata_i[btc_pkg::BIT_UPD_SOURCE];
      ctrl_r.one_pulse_sel     <= pwdata_i[btc_pkg::BIT_ONE_PULSE];
      ctrl_r.reload_buffer_en  <= pwdata_i[btc_pkg::BIT_RELOAD_BUF];
    end else if (update_event && ctrl_r.one_pulse_sel) begin
      ctrl_r.counter_run <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      master_trigger_sel_r <= btc_pkg::TRS_RESET;
    end else if (wr_ctrl_two) begin
      master_trigger_sel_r <= pwdata_i[btc_pkg::TRS_LSB +: btc_pkg::TRS_W];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mask_r <= btc_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_r.irq_en <= pwdata_i[btc_pkg::BIT_IRQ_EN];
      mask_r.dma_en <= pwdata_i[btc_pkg::BIT_DMA_EN];
    end
  end

  // ----------------------------------------------------------------
  // Preload and shadow registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      divider_pre_r <= btc_pkg::DIVIDER_RST;
      reload_pre_r  <= RELOAD_INI;
    end else begin
      if (wr_divider) begin
        divider_pre_r <= pwdata_i[CNT_W-1:0];
      end
      if (wr_reload) begin
        reload_pre_r <= pwdata_i[CNT_W-1:0];
      end
    end
  end

  // Shadows move only on an update event, so a disabled update keeps them
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      divider_act_r <= btc_pkg::DIVIDER_RST;
      reload_shd_r  <= RELOAD_INI;
    end else if (update_event) begin
      divider_act_r <= divider_pre_r;
      reload_shd_r  <= reload_pre_r;
    end
  end

  // Unbuffered: a reload write is seen by the compare at once
  assign reload_value = ctrl_r.reload_buffer_en ? reload_shd_r : reload_pre_r;

  // ----------------------------------------------------------------
  // Update event
  // ----------------------------------------------------------------
  assign reinit       = force_update || slv_reset_i;
  assign update_event = !ctrl_r.update_disable &&
                        (ovf || force_update || slv_update_i);
  assign flag_set     = update_event &&
                        (!ctrl_r.update_source_sel || ovf);

  // Set wins over a clear written in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      upd_flag_r <= 1'b0;
    end else if (flag_set) begin
      upd_flag_r <= 1'b1;
    end else if (wr_status && pwdata_i[btc_pkg::BIT_UPD_FLAG]) begin
      upd_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_r     <= 1'b0;
      dma_req_r <= 1'b0;
    end else begin
      irq_r     <= upd_flag_r && mask_r.irq_en;
      dma_req_r <= flag_set && mask_r.dma_en;
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  btc_time_base #(
    .CNT_W (CNT_W)
  ) u_time_base (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .run_i       (ctrl_r.counter_run),
    .reinit_i    (reinit),
    .cnt_load_i  (wr_count),
    .cnt_wdata_i (pwdata_i[CNT_W-1:0]),
    .divider_i   (divider_act_r),
    .reload_i    (reload_value),
    .cnt_o       (cnt),
    .ovf_o       (ovf)
  );

  // ----------------------------------------------------------------
  // Trigger output
  // ----------------------------------------------------------------
  // Registered, so a slave-reset pulse leaves one cycle after the reset.
  // The receiver must have its clock running and stable first.
  assign counter_run_signal = ctrl_r.counter_run || gate_trig_i;

  always_comb begin
    trigger_out_nxt = 1'b0;
    case (master_trigger_sel_r)
      btc_pkg::TRS_RESET:  trigger_out_nxt = reinit;
      btc_pkg::TRS_ENABLE: trigger_out_nxt = counter_run_signal;
      btc_pkg::TRS_UPDATE: trigger_out_nxt = update_event;
      default:             trigger_out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trigger_out_r <= 1'b0;
    end else begin
      trigger_out_r <= trigger_out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o      = prdata_r;
  assign pready_o      = pready_r;
  assign pslverr_o     = pslverr_r;
  assign trigger_out_o = trigger_out_r;
  assign irq_o         = irq_r;
  assign dma_req_o     = dma_req_r;

endmodule

// File: tb/btc_timer_properties.sv
// Concurrent checks of the basic timer control, seen from its top ports.
// Assumes APB and slave-mode inputs are synchronous to sys_clk_i.
`timescale 1ns/10ps
module btc_timer_properties #(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // Slave mode and events
  input  wire logic        slv_reset_i,
  input  wire logic        slv_update_i,
  input  wire logic        gate_trig_i,
  input  wire logic        trigger_out_o,
  input  wire logic        irq_o,
  input  wire logic        dma_req_o
);
  // ----------------------------------------
  // Shadow of the software settings
  // ----------------------------------------
  // Hardware may clear run behind our back, so run_r low only proves a stopped counter
  logic       wr_done;
  logic       ewr;
  logic [2:0] trs_r;
  logic       run_r;
  logic       src_r;
  logic       nupd_r;
  logic       irq_en_r;
  logic       dma_en_r;
  assign wr_done = psel_i & penable_i & pready_o & pwrite_i & !pslverr_o;
  assign ewr = wr_done & (paddr_i == 12'h014) & pwdata_i[0];
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      {trs_r, run_r, src_r, nupd_r, irq_en_r, dma_en_r} <= 8'h00;
    end else if (wr_done && paddr_i == 12'h000) begin
      {src_r, nupd_r, run_r} <= pwdata_i[2:0];
    end else if (wr_done && paddr_i == 12'h004) begin
      trs_r <= pwdata_i[6:4];
    end else if (wr_done && paddr_i == 12'h00c) begin
      {dma_en_r, irq_en_r} <= {pwdata_i[8], pwdata_i[0]};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RESET_QUIET: assert property ($fell(sys_rst_i) |-> !trigger_out_o && !irq_o && !dma_req_o)
    else $error("event output active after reset");
  AST_TRIG_FORCE: assert property (ewr && trs_r == 3'h0 |-> ##[1:2] trigger_out_o)
    else $error("no trigger after forced update");
  AST_TRIG_SLV_RESET: assert property (slv_reset_i && trs_r == 3'h0 |=> trigger_out_o)
    else $error("no trigger after slave reset");
  AST_TRIG_GATE: assert property (trs_r == 3'h1 && gate_trig_i |=> trigger_out_o)
    else $error("trigger does not follow gate input");
  AST_TRIG_UPDATE: assert property (trs_r == 3'h2 && !nupd_r && slv_update_i |=> trigger_out_o)
    else $error("trigger missing on update event");
  AST_TRIG_RESERVED: assert property (trs_r > 3'h2 |=> !trigger_out_o)
    else $error("trigger active in reserved mode");
  AST_DMA_ALL_SOURCES: assert property (!nupd_r && !src_r && dma_en_r && slv_update_i |=> dma_req_o)
    else $error("slave update raised no request");
  AST_DMA_OVF_ONLY: assert property (src_r && !run_r |=> !dma_req_o)
    else $error("request without overflow");
  AST_NO_UPDATE: assert property (nupd_r |=> !dma_req_o)
    else $error("request while updates disabled");
  AST_IRQ_MASKED: assert property (irq_o |-> $past(irq_en_r))
    else $error("interrupt while masked");
  COV_FORCE: cover property (ewr && trs_r == 3'h0);
  COV_DMA: cover property (dma_req_o);
  COV_IRQ: cover property (irq_o);
endmodule

bind btc_timer btc_timer_properties #(.CNT_W(CNT_W)) btc_timer_properties_i (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .slv_reset_i(slv_reset_i), .slv_update_i(slv_update_i), .gate_trig_i(gate_trig_i),
  .trigger_out_o(trigger_out_o), .irq_o(irq_o), .dma_req_o(dma_req_o)
);

// File: tb/btc_trig_rx.sv
// Slave timer model that takes the trigger output as its count clock.
// Assumes it shares sys_clk_i with the master timer.
`timescale 1ns/10ps
module btc_trig_rx (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Trigger from the master
  input  wire logic        clk_en_i,
  input  wire logic        trigger_out_i,
  // Rising edges seen
  output logic      [15:0] edges_o
);
  logic prev_r;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prev_r  <= 1'b0;
      edges_o <= 16'h0000;
    end else if (clk_en_i) begin
      prev_r <= trigger_out_i;
      if (trigger_out_i && !prev_r) begin
        edges_o <= edges_o + 16'h0001;
      end
    end
  end
endmodule

// File: tb/btc_timer_bench.sv
// Self-checking bench of the basic timer control with a slave timer model.
// Assumes the design, its bound checker and the model are compiled first.
`timescale 1ns/10ps
module btc_timer_bench;
  logic        sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, rx_en;
  logic        slv_reset_i, slv_update_i, gate_trig_i, pready_o, pslverr_o;
  logic        trigger_out_o, irq_o, dma_req_o, e;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q, v, b, x;
  logic [15:0] rx_edges, e0;
  int          n_fail, n_compared, cyc, t_done, dma_cnt, t1, n, d0;
  logic [11:0] ofs [8] = '{12'h000, 12'h004, 12'h00c, 12'h010, 12'h014, 12'h024, 12'h028, 12'h02c};
  int          exp_edges [8] = '{2, 1, 2, 0, 0, 0, 0, 0};

  btc_timer btc_timer_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .slv_reset_i(slv_reset_i), .slv_update_i(slv_update_i), .gate_trig_i(gate_trig_i),
    .trigger_out_o(trigger_out_o), .irq_o(irq_o), .dma_req_o(dma_req_o)
  );
  btc_trig_rx btc_trig_rx_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(rx_en),
    .trigger_out_i(trigger_out_o), .edges_o(rx_edges)
  );

  // ----------------------------------------
  // Clock, cycle count and timeout
  // ----------------------------------------
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (dma_req_o === 1'b1) begin
      dma_cnt <= dma_cnt + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {psel_i, penable_i, pwrite_i} <= {1'b1, 1'b0, w};
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    t_done = cyc;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] xp);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), q, xp);
  endtask
  task automatic slv(input logic [2:0] s);
    @(posedge sys_clk_i);
    {gate_trig_i, slv_update_i, slv_reset_i} <= s;
    @(posedge sys_clk_i);
    {gate_trig_i, slv_update_i, slv_reset_i} <= 3'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {sys_clk_i, psel_i, penable_i, pwrite_i, slv_reset_i, slv_update_i, gate_trig_i} = 7'h00;
    {paddr_i, pwdata_i, sys_rst_i, rx_en} = {12'h000, 32'h0000_0000, 1'b1, 1'b1};
    v = $urandom(13);
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], (i == 7) ? 32'h0000_ffff : 32'h0000_0000);
    rd(12'h030, 32'h0000_0000);
    chk("slave error", {31'h0, e}, 32'h0000_0001);
    v = $urandom;
    apb(1'b1, 12'h000, v & 32'hffff_fffe);
    rd(12'h000, v & 32'h0000_008e);
    apb(1'b1, 12'h004, v);
    rd(12'h004, v & 32'h0000_0070);
    // Preload, buffered preload, frozen shadow and divide by two, each against its own measured run length
    for (int m = 0; m < 4; m++) begin
      b = (m == 1) ? 32'h80 : ((m == 2) ? 32'h82 : 32'h0);
      apb(1'b1, 12'h000, b & 32'h0000_0080);
      apb(1'b1, 12'h028, m / 3);
      apb(1'b1, 12'h02c, 32'h0000_0002);
      apb(1'b1, 12'h014, 32'h0000_0001);
      apb(1'b1, 12'h02c, 32'h0000_00ff);
      apb(1'b1, 12'h000, b | 32'h0000_0001);
      t1 = t_done;
      repeat ($urandom_range(40, 5)) @(posedge sys_clk_i);
      apb(1'b1, 12'h000, b);
      n = t_done - t1;
      x = (m == 1) ? n - 3 : ((m == 2) ? n % 3 : ((m == 3) ? n / 2 : n));
      rd(12'h024, x);
    end
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h02c, 32'h0000_0003);
    apb(1'b1, 12'h014, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_0001);
    apb(1'b1, 12'h00c, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0009);
    repeat (12) @(posedge sys_clk_i);
    rd(12'h000, 32'h0000_0008);
    rd(12'h024, 32'h0000_0000);
    rd(12'h010, 32'h0000_0001);
    chk("irq", {31'h0, irq_o}, 32'h0000_0001);
    apb(1'b1, 12'h00c, 32'h0000_0100);
    repeat (2) @(posedge sys_clk_i);
    chk("irq masked", {31'h0, irq_o}, 32'h0000_0000);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 12'h010, 32'h0000_0001);
      apb(1'b1, 12'h000, s << 2);
      d0 = dma_cnt;
      slv(3'h2);
      apb(1'b1, 12'h014, 32'h0000_0001);
      repeat (3) @(posedge sys_clk_i);
      chk("dma count", dma_cnt - d0, (s == 1) ? 0 : 2);
      rd(12'h010, (s == 1) ? 0 : 1);
    end
    apb(1'b1, 12'h000, 32'h0000_0002);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h024, 32'h0000_0055);
      if (k == 0) begin
        apb(1'b1, 12'h014, 32'h0000_0001);
      end else begin
        slv(3'h1);
      end
      rd(12'h024, 32'h0000_0000);
    end
    rd(12'h010, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h004, c << 4);
      e0 = rx_edges;
      apb(1'b1, 12'h014, 32'h0000_0001);
      slv(3'h1);
      slv(3'h2);
      slv(3'h4);
      chk("trigger edges", rx_edges - e0, exp_edges[c]);
    end
    print_verdict();
  end
endmodule
